/* core/sfotp_pkg.sv */
package sfotp_pkg;
	// Command codes
	localparam logic [7:0] OP_OTP_PROGRAM = 8'h42;
	localparam logic [7:0] OP_OTP_READ = 8'h4b;
	localparam logic [7:0] OP_WRITE_ENABLE = 8'h06;
	localparam logic [7:0] OP_WRITE_DISABLE = 8'h04;
	// Frame layout in whole bytes: opcode, three address bytes, then data or dummy
	localparam logic [2:0] BYTE_OPCODE = 3'h0;
	localparam logic [2:0] BYTE_ADDR_HI = 3'h1;
	localparam logic [2:0] BYTE_ADDR_MID = 3'h2;
	localparam logic [2:0] BYTE_ADDR_LO = 3'h3;
	localparam logic [2:0] BYTE_DATA = 3'h4;
	localparam logic [2:0] BYTES_CMD_ONLY = 3'h1;
	localparam logic [2:0] BYTES_PROGRAM = 3'h5;
	localparam logic [2:0] BYTES_READ_OUT = 3'h5;
	localparam logic [2:0] BYTES_SATURATE = 3'h7;
	// OTP address map
	localparam logic [9:0] ADDR_SN_LOCK = 10'h100;
	localparam logic [9:0] ADDR_RESERVED = 10'h101;
	localparam logic [9:0] ADDR_LSN_FIRST = 10'h102;
	localparam logic [9:0] ADDR_USN_FIRST = 10'h10a;
	localparam logic [9:0] ADDR_LOCK_LOW_A = 10'h112;
	localparam logic [9:0] ADDR_LOCK_LOW_B = 10'h113;
	localparam logic [9:0] ADDR_REGION1 = 10'h114;
	localparam logic [9:0] ADDR_LOCK_HIGH_A = 10'h214;
	localparam logic [9:0] ADDR_LOCK_HIGH_B = 10'h215;
	localparam logic [9:0] ADDR_REGION17 = 10'h216;
	localparam logic [9:0] ADDR_TOP = 10'h2ff;
	localparam int OTP_DEPTH = 512;
	localparam int SN_BYTES = 8;
	// Lock bit positions and masks
	localparam int LSN_LOCK_BIT = 0;
	localparam int USN_LOCK_BIT = 1;
	localparam logic [7:0] SN_LOCK_FIXED = 8'hfc;
	localparam logic [7:0] HIGH_LOCK_FIXED = 8'h80;
	localparam logic [7:0] ERASED_BYTE = 8'hff;
	localparam logic [7:0] FACTORY_SN_LOCK = 8'hfe;
	localparam logic [7:0] NO_MASK = 8'h00;
endpackage

/* core/sfotp_access.sv */
`timescale 1ns/1ps
`default_nettype none

// Notes on behaviour
// - OTP read frames like fast read; past top address data is undefined, no wrap.
// - OTP space: two 8-byte serial regions, thirty 16-byte, one 10-byte, each lockable.
// - Lower serial region ships with a random 64-bit value and locked.
// - A locked region never changes again; lock bits never clear.
// - Power-up, reset and end of each OTP command return addressing to main array.
// - OTP program outside valid OTP range is silently ignored.
// - OTP read outside valid OTP range returns undefined data.
// - No OTP access while an embedded program or erase runs.
// - Program acceleration stays off during any OTP access.
// - OTP program is 42h, opcode, three address bytes, then data.
// - Repeated programs to one address allowed; OTP cannot be erased.
// - OTP read is 4Bh, opcode, three address bytes, dummy byte, then data.
// - Programming a region stops once its lock bit is programmed.
// - Lock byte 0x100: bit 0 locks lower, bit 1 upper serial region.
// - Bits 2 to 7 of 0x100 are not programmable and ignored.
// - Bytes 0x214/0x215 lock regions 17 to 31 ascending; 0x215 bit 7 ignored.
// - Device comes up in standby with write enable latch cleared.
// - OTP program ignored unless it carries exactly one data byte.
module sfotp_access #(
	parameter logic [63:0] SERIAL_NUMBER = 64'h5a5a_1234_c3c3_9876 // Arbitrary value
) (
	input wire logic clk,
	input wire logic rst_n,
	input wire logic sck,
	input wire logic cs_n,
	input wire logic si,
	input wire logic embedded_busy,
	input wire logic accel_request,
	output logic so,
	output logic so_oe,
	output logic otp_space_selected,
	output logic program_acceleration,
	output logic write_enable_latch,
	output logic standby,
	output logic otp_program_done
);

	function automatic logic addr_valid(input logic [23:0] a);
		addr_valid = (a[23:10] == 14'h0000) && (a[9:8] == 2'h1 || a[9:8] == 2'h2);
	endfunction

	function automatic logic [8:0] mem_index(input logic [9:0] a);
		mem_index = {a[9], a[7:0]};
	endfunction

	function automatic logic region_locked(input logic [9:0] a, input logic [7:0] sn,
			input logic [15:0] la, input logic [15:0] lb);
		logic [9:0] off_a;
		logic [9:0] off_b;
		off_a = a - sfotp_pkg::ADDR_REGION1;
		off_b = a - sfotp_pkg::ADDR_REGION17;
		if (a == sfotp_pkg::ADDR_RESERVED) begin
			region_locked = 1'b1;
		end else if (a >= sfotp_pkg::ADDR_LSN_FIRST && a < sfotp_pkg::ADDR_USN_FIRST) begin
			region_locked = ~sn[sfotp_pkg::LSN_LOCK_BIT];
		end else if (a >= sfotp_pkg::ADDR_USN_FIRST && a < sfotp_pkg::ADDR_LOCK_LOW_A) begin
			region_locked = ~sn[sfotp_pkg::USN_LOCK_BIT];
		end else if (a >= sfotp_pkg::ADDR_REGION1 && a < sfotp_pkg::ADDR_LOCK_HIGH_A) begin
			region_locked = ~la[off_a[7:4]];
		end else if (a >= sfotp_pkg::ADDR_REGION17) begin
			region_locked = ~lb[off_b[7:4]];
		end else begin
			region_locked = 1'b0;
		end
	endfunction

	// ---------------- Link side, on the serial clock ----------------
	logic first_reg;
	logic frame_tag_reg;
	logic tag_seen_reg;
	logic otp_frame_reg;
	logic [2:0] bitn_reg;
	logic [2:0] nbytes_reg;
	logic [7:0] shift_reg;
	logic [7:0] opcode_reg;
	logic [7:0] data_reg;
	logic [23:0] addr_reg;
	logic [23:0] rd_addr_reg;
	logic rd_toggle_reg;
	logic [7:0] tx_reg;
	logic so_reg;
	logic so_oe_reg;
	logic [7:0] rd_data_reg;

	wire [2:0] bitn_cur = first_reg ? 3'h0 : bitn_reg;
	wire [2:0] nbytes_cur = first_reg ? 3'h0 : nbytes_reg;
	wire [7:0] shift_next = {shift_reg[6:0], si};
	wire byte_done = bitn_cur == 3'h7;
	wire is_read = opcode_reg == sfotp_pkg::OP_OTP_READ;
	wire opcode_otp = shift_next == sfotp_pkg::OP_OTP_READ
		|| shift_next == sfotp_pkg::OP_OTP_PROGRAM;
	wire rd_start = byte_done && nbytes_cur == sfotp_pkg::BYTE_ADDR_LO && is_read;
	wire rd_next = byte_done && nbytes_cur >= sfotp_pkg::BYTE_DATA && is_read;
	wire read_out = is_read && nbytes_reg >= sfotp_pkg::BYTES_READ_OUT;
	wire [2:0] tx_bit = 3'h7 - bitn_reg;

	// Chip select high is the frame boundary; the serial clock may stand still there
	always_ff @(posedge sck or posedge cs_n) begin
		if (cs_n) begin
			first_reg <= 1'b1;
		end else begin
			first_reg <= 1'b0;
		end
	end

	// OTP addressing only lasts while the OTP frame is selected
	always_ff @(posedge sck or posedge cs_n) begin
		if (cs_n) begin
			otp_frame_reg <= 1'b0;
		end else if (byte_done && nbytes_cur == sfotp_pkg::BYTE_OPCODE && opcode_otp) begin
			otp_frame_reg <= 1'b1;
		end
	end

	always_ff @(posedge sck) begin
		shift_reg <= shift_next;
		bitn_reg <= bitn_cur + 3'h1;
		if (byte_done && nbytes_cur != sfotp_pkg::BYTES_SATURATE) begin
			nbytes_reg <= nbytes_cur + 3'h1;
		end else begin
			nbytes_reg <= nbytes_cur;
		end
		// The core only updates its copy while chip select is high, so it is still here
		if (first_reg) begin
			frame_tag_reg <= ~tag_seen_reg;
		end
	end

	always_ff @(posedge sck) begin
		if (byte_done) begin
			case (nbytes_cur)
				sfotp_pkg::BYTE_OPCODE: opcode_reg <= shift_next;
				sfotp_pkg::BYTE_ADDR_HI: addr_reg[23:16] <= shift_next;
				sfotp_pkg::BYTE_ADDR_MID: addr_reg[15:8] <= shift_next;
				sfotp_pkg::BYTE_ADDR_LO: addr_reg[7:0] <= shift_next;
				sfotp_pkg::BYTE_DATA: data_reg <= shift_next;
				default: data_reg <= data_reg;
			endcase
		end
	end

	// Each fetch is requested one whole byte ahead of its use, which leaves
	// eight serial clocks for the toggle to cross and the byte to settle
	always_ff @(posedge sck) begin
		if (rd_start) begin
			rd_addr_reg <= {addr_reg[23:8], shift_next};
		end else if (rd_next) begin
			tx_reg <= rd_data_reg;
			rd_addr_reg <= rd_addr_reg + 24'h00_0001;
		end
	end

	// Cleared between frames so the request toggle never starts unknown
	always_ff @(posedge sck or posedge cs_n) begin
		if (cs_n) begin
			rd_toggle_reg <= 1'b0;
		end else if (rd_start || rd_next) begin
			rd_toggle_reg <= ~rd_toggle_reg;
		end
	end

	always_ff @(negedge sck or posedge cs_n) begin
		if (cs_n) begin
			so_reg <= 1'b0;
			so_oe_reg <= 1'b0;
		end else begin
			so_reg <= tx_bit == 3'h0 ? tx_reg[0] : tx_reg[tx_bit];
			so_oe_reg <= read_out;
		end
	end

	assign so = so_reg;
	assign so_oe = so_oe_reg;

	// ---------------- Core side, on clk ----------------
	logic [7:0] mem [0:sfotp_pkg::OTP_DEPTH-1];
	logic cs_s1_reg;
	logic cs_s2_reg;
	logic cs_s3_reg;
	logic rq_s1_reg;
	logic rq_s2_reg;
	logic rq_s3_reg;
	logic of_s1_reg;
	logic of_s2_reg;
	logic acc_s1_reg;
	logic acc_s2_reg;
	logic otp_sel_reg;
	logic accel_reg;
	logic wel_reg;
	logic standby_reg;
	logic done_reg;

	// Delivery state: erased, with the lower serial region written and locked
	initial begin
		for (int i = 0; i < sfotp_pkg::OTP_DEPTH; i++) begin
			mem[i] = sfotp_pkg::ERASED_BYTE;
		end
		for (int i = 0; i < sfotp_pkg::SN_BYTES; i++) begin
			mem[int'(mem_index(sfotp_pkg::ADDR_LSN_FIRST)) + i] =
				SERIAL_NUMBER[8*i +: 8];
		end
		mem[mem_index(sfotp_pkg::ADDR_SN_LOCK)] = sfotp_pkg::FACTORY_SN_LOCK;
	end

	wire [7:0] lock_sn = mem[mem_index(sfotp_pkg::ADDR_SN_LOCK)];
	wire [15:0] lock_low = {mem[mem_index(sfotp_pkg::ADDR_LOCK_LOW_B)],
		mem[mem_index(sfotp_pkg::ADDR_LOCK_LOW_A)]};
	wire [15:0] lock_high = {mem[mem_index(sfotp_pkg::ADDR_LOCK_HIGH_B)],
		mem[mem_index(sfotp_pkg::ADDR_LOCK_HIGH_A)]};

	// Frame fields are still while chip select is high, so they are read directly
	wire frame_end = cs_s2_reg & ~cs_s3_reg;
	wire fresh = frame_tag_reg != tag_seen_reg;
	wire whole_bytes = bitn_reg == 3'h0;
	wire [9:0] pa = addr_reg[9:0];
	wire [8:0] pidx = mem_index(pa);
	wire prog_frame = frame_end && fresh && whole_bytes
		&& opcode_reg == sfotp_pkg::OP_OTP_PROGRAM
		&& nbytes_reg == sfotp_pkg::BYTES_PROGRAM;
	wire cmd_frame = frame_end && fresh && whole_bytes
		&& nbytes_reg == sfotp_pkg::BYTES_CMD_ONLY;
	wire write_enable_command_frame = cmd_frame && opcode_reg == sfotp_pkg::OP_WRITE_ENABLE;
	wire wrdi_frame = cmd_frame && opcode_reg == sfotp_pkg::OP_WRITE_DISABLE;
	wire locked = region_locked(pa, lock_sn, lock_low, lock_high);
	wire commit = prog_frame && wel_reg && !embedded_busy
		&& addr_valid(addr_reg) && !locked;
	wire [7:0] fixed_bits = pa == sfotp_pkg::ADDR_SN_LOCK ? sfotp_pkg::SN_LOCK_FIXED
		: pa == sfotp_pkg::ADDR_LOCK_HIGH_B ? sfotp_pkg::HIGH_LOCK_FIXED
		: sfotp_pkg::NO_MASK;
	wire [7:0] prog_byte = mem[pidx] & (data_reg | fixed_bits);
	wire rd_event = rq_s2_reg ^ rq_s3_reg;
	wire rd_ok = addr_valid(rd_addr_reg) && !embedded_busy;
	wire [7:0] rd_fetch = rd_ok ? mem[mem_index(rd_addr_reg[9:0])] : sfotp_pkg::ERASED_BYTE;

	always_ff @(posedge clk) begin
		cs_s1_reg <= cs_n;
		cs_s2_reg <= cs_s1_reg;
		cs_s3_reg <= cs_s2_reg;
		rq_s1_reg <= rd_toggle_reg;
		rq_s2_reg <= rq_s1_reg;
		rq_s3_reg <= rq_s2_reg;
		of_s1_reg <= otp_frame_reg;
		of_s2_reg <= of_s1_reg;
		acc_s1_reg <= accel_request;
		acc_s2_reg <= acc_s1_reg;
	end

	// Bits only ever go from one to zero; nothing here can raise them again
	// Plain always: the delivery-state initial block also writes the array
	always @(posedge clk) begin
		if (commit) begin
			mem[pidx] <= prog_byte;
		end
	end

	always_ff @(posedge clk) begin
		if (rd_event) begin
			rd_data_reg <= rd_fetch;
		end
	end

	always_ff @(posedge clk) begin
		if (!rst_n) begin
			tag_seen_reg <= 1'b0;
			otp_sel_reg <= 1'b0;
			accel_reg <= 1'b0;
			standby_reg <= 1'b1;
			done_reg <= 1'b0;
		end else begin
			if (frame_end) begin
				tag_seen_reg <= frame_tag_reg;
			end
			otp_sel_reg <= of_s2_reg;
			accel_reg <= acc_s2_reg && !of_s2_reg && !commit;
			standby_reg <= cs_s2_reg && !embedded_busy;
			done_reg <= commit;
		end
	end

	always_ff @(posedge clk) begin
		if (!rst_n) begin
			wel_reg <= 1'b0;
		end else if (write_enable_command_frame) begin
			wel_reg <= 1'b1;
		end else if (commit || wrdi_frame) begin
			wel_reg <= 1'b0;
		end
	end

	assign otp_space_selected = otp_sel_reg;
	assign program_acceleration = accel_reg;
	assign write_enable_latch = wel_reg;
	assign standby = standby_reg;
	assign otp_program_done = done_reg;

endmodule

`default_nettype wire

/* tb/sfotp_assertions.sv */
`timescale 1ns/1ps
`default_nettype none
module sfotp_assertions (
	input wire logic clk,
	input wire logic rst_n,
	input wire logic cs_n,
	input wire logic embedded_busy,
	input wire logic accel_request,
	input wire logic otp_space_selected,
	input wire logic program_acceleration,
	input wire logic write_enable_latch,
	input wire logic standby,
	input wire logic otp_program_done
);
	default clocking @(posedge clk); endclocking
	default disable iff (!rst_n);
	accel_off_a: assert property (otp_space_selected |-> !program_acceleration)
		else $error("acceleration during otp frame");
	accel_low_a: assert property (!accel_request [*4] |-> !program_acceleration)
		else $error("acceleration without request");
	reset_state_a: assert property (disable iff (1'b0) !rst_n |=>
		!otp_space_selected && !write_enable_latch && standby && !otp_program_done)
		else $error("outputs not at reset values");
	busy_standby_a: assert property (embedded_busy |=> !standby)
		else $error("standby while busy");
	done_busy_a: assert property (otp_program_done |-> !$past(embedded_busy))
		else $error("write while busy");
	sel_drop_a: assert property (cs_n [*6] |-> !otp_space_selected)
		else $error("otp space kept after frame");
	done_wel_a: assert property (
		otp_program_done |-> !write_enable_latch && $past(write_enable_latch, 2))
		else $error("write without latch set");
	done_pulse_a: assert property (otp_program_done |=> !otp_program_done)
		else $error("done longer than one cycle");
endmodule
bind sfotp_access sfotp_assertions i_chk (.clk, .rst_n, .cs_n, .embedded_busy,
	.accel_request, .otp_space_selected, .program_acceleration, .write_enable_latch,
	.standby, .otp_program_done);
`default_nettype wire

/* tb/sfotp_host_model.sv */
`timescale 1ns/1ps
`default_nettype none
module sfotp_host_model (
	output logic cs_n,
	output logic sck,
	output logic si,
	input wire logic so
);
	initial begin
		sck = 1'b0;
		si = 1'b0;
		// The rise from unknown gives the link logic its first frame-boundary clear
		#1 cs_n = 1'b1;
	end
	// Sends nt bytes MSB first, then shifts in nr bytes; clock stands low between frames
	task automatic frame(input logic [127:0] tx, input int nt, input int nr,
		output logic [63:0] rx);
		int i;
		rx = 64'h0;
		#7 cs_n = 1'b0;
		for (i = 0; i < 8 * (nt + nr); i++) begin
			si = (i < 8 * nt) ? tx[127 - i] : ~si;
			#62.5 sck = 1'b1;
			if (i >= 8 * nt) rx = {rx[62:0], so};
			#62.5 sck = 1'b0;
		end
		#40 cs_n = 1'b1;
		si = ~si;
		#300;
	endtask
endmodule
`default_nettype wire

/* tb/testbench.sv */
`timescale 1ns/1ps
`default_nettype none
module testbench;
	localparam logic [63:0] SN = 64'h0123_4567_89ab_cdef; // Arbitrary value
	logic clk = 1'b0;
	logic rst_n = 1'b0;
	logic embedded_busy = 1'b0;
	logic accel_request = 1'b0;
	wire logic cs_n, sck, si, so, so_oe, otp_space_selected, program_acceleration;
	wire logic write_enable_latch, standby, otp_program_done;
	int n_mismatch = 0;
	int check_count = 0;
	int n_done = 0;
	int n_oe = 0;
	int k;
	logic [31:0] lfsr = 32'hd15d_7be1;
	logic [63:0] rx;
	logic [9:0] a;
	logic [7:0] d;
	sfotp_access #(.SERIAL_NUMBER(SN)) i_dut (.clk, .rst_n, .sck, .cs_n, .si, .embedded_busy,
		.accel_request, .so, .so_oe, .otp_space_selected, .program_acceleration,
		.write_enable_latch, .standby, .otp_program_done);
	sfotp_host_model i_host (.cs_n, .sck, .si, .so);
	always #25 clk = ~clk;
	always @(posedge clk) if (otp_program_done === 1'b1) n_done <= n_done + 1;
	always @(posedge sck) if (so_oe === 1'b1) n_oe <= n_oe + 1;
	function automatic logic [31:0] step(input logic [31:0] s);
		return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
	endfunction
	task automatic chk(input string nm, input logic [63:0] e, input logic [63:0] g);
		check_count++;
		if (g !== e) begin
			n_mismatch++;
			$display("BAD %s expected %h seen %h", nm, e, g);
		end
	endtask
	task automatic wrap_up;
		$display("checks %0d mismatches %0d", check_count, n_mismatch);
		if (n_mismatch == 0 && check_count > 0) $display("Simulation passed");
		else $display("Simulation failed");
		$finish;
	endtask
	task automatic cmd(input logic [7:0] op);
		i_host.frame({op, 120'h0}, 1, 0, rx);
	endtask
	task automatic rd(input logic [9:0] ad, input int n);
		int n0;
		n0 = n_oe;
		i_host.frame({sfotp_pkg::OP_OTP_READ, 14'h0, ad, 96'h0}, 5, n, rx);
		chk("so_oe", 64'(8 * n), 64'(n_oe - n0));
	endtask
	// Done count and latch state tell whether the byte was committed
	task automatic prog(input logic [9:0] ad, input logic [7:0] v, input int nd, input bit we,
		input bit ok);
		int n0;
		if (we) cmd(sfotp_pkg::OP_WRITE_ENABLE);
		n0 = n_done;
		i_host.frame({sfotp_pkg::OP_OTP_PROGRAM, 14'h0, ad, v, v, 80'h0}, 4 + nd, 0, rx);
		repeat (8) @(posedge clk);
		chk("done", 64'(ok), 64'(n_done - n0));
		chk("wel", 64'(!ok && we), {63'h0, write_enable_latch});
	endtask
	initial begin
		#2ms;
		n_mismatch++;
		wrap_up;
	end
	initial begin
		repeat (5) @(posedge clk);
		rst_n <= 1'b1;
		repeat (4) @(posedge clk);
		chk("wel", 64'h0, {63'h0, write_enable_latch});
		chk("standby", 64'h1, {63'h0, standby});
		rd(10'h102, 8);
		chk("serial", {<<8{SN}}, rx);
		rd(10'h100, 1);
		chk("sn lock", 64'hfe, rx);
		@(posedge clk);
		accel_request <= 1'b1;
		for (k = 0; k < 3; k++) begin
			lfsr = step(lfsr);
			a = 10'h124 + {3'h0, k[1:0], lfsr[4:0]};
			d = lfsr[15:8];
			prog(a, d, 1, 1'b1, 1'b1);
			rd(a, 1);
			chk("byte", {56'h0, d}, rx);
			chk("accel", 64'h1, {63'h0, program_acceleration});
			chk("otp sel", 64'h0, {63'h0, otp_space_selected});
			prog(a, lfsr[23:16], 1, 1'b1, 1'b1);
			rd(a, 1);
			chk("and", {56'h0, d & lfsr[23:16]}, rx);
		end
		prog(10'h114, 8'h00, 1, 1'b0, 1'b0);
		prog(10'h114, 8'h00, 2, 1'b1, 1'b0);
		prog(10'h300, 8'h00, 1, 1'b1, 1'b0);
		embedded_busy <= 1'b1;
		prog(10'h114, 8'h00, 1, 1'b1, 1'b0);
		rd(10'h100, 1);
		chk("busy read", 64'hff, rx);
		@(posedge clk);
		embedded_busy <= 1'b0;
		rd(10'h114, 1);
		chk("refused", 64'hff, rx);
		rd(10'h050, 1);
		chk("outside", 64'hff, rx);
		rd(10'h2ff, 2);
		chk("top", 64'hffff, rx);
		prog(10'h112, 8'hfe, 1, 1'b1, 1'b1);
		prog(10'h114, 8'h00, 1, 1'b1, 1'b0);
		prog(10'h112, 8'hff, 1, 1'b1, 1'b1);
		prog(10'h102, 8'h00, 1, 1'b1, 1'b0);
		rd(10'h112, 1);
		chk("lock kept", 64'hfe, rx);
		prog(10'h100, 8'h00, 1, 1'b1, 1'b1);
		rd(10'h100, 1);
		chk("sn lock", 64'hfc, rx);
		prog(10'h215, 8'h00, 1, 1'b1, 1'b1);
		rd(10'h215, 1);
		chk("high lock", 64'h80, rx);
		cmd(sfotp_pkg::OP_WRITE_ENABLE);
		cmd(sfotp_pkg::OP_WRITE_DISABLE);
		repeat (8) @(posedge clk);
		chk("wel off", 64'h0, {63'h0, write_enable_latch});
		cmd(sfotp_pkg::OP_WRITE_ENABLE);
		repeat (8) @(posedge clk);
		chk("wel", 64'h1, {63'h0, write_enable_latch});
		rst_n <= 1'b0;
		repeat (5) @(posedge clk);
		rst_n <= 1'b1;
		repeat (4) @(posedge clk);
		chk("wel", 64'h0, {63'h0, write_enable_latch});
		rd(10'h112, 1);
		chk("kept", 64'hfe, rx);
		wrap_up;
	end
endmodule
`default_nettype wire
